// ---- src/bit_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
module bit_fifo #(
  parameter int WIDTH = electrode_pkg::FIFO_WIDTH,
  parameter int DEPTH = electrode_pkg::FIFO_DEPTH
) (
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ff;
  logic [PW-1:0]    rd_ff;
  logic [CW-1:0]    cnt_ff;
  logic [PW-1:0]    nxt_wr;
  logic [PW-1:0]    nxt_rd;
  logic [CW-1:0]    nxt_cnt;
  logic             push;
  logic             pop;

  // Pointer wrap, used by both pointers
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Handshake flags come straight from the occupancy count
  assign in_ready_o  = (cnt_ff != CW'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem_ff[rd_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Next pointers and count
  always_comb begin
    nxt_wr  = push ? bump(wr_ff) : wr_ff;
    nxt_rd  = pop ? bump(rd_ff) : rd_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + CW'(1);
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - CW'(1);
    end
  end

  // Storage needs no reset; only written words are ever read
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  // Pointer registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// ---- src/electrode_pkg.sv ----
// Constants shared by the electrode shift driver and its input FIFO
// Summary of operation
// - Each shift clock rise loads first_stage; stages move one on (here via the FIFO: a rise seen while it is full is dropped)
// - Without a rising shift clock every stage keeps its value (here queued bits still shift in once shift_hold_i falls)
// - Cascade output shows last_stage and changes only after a shift
// - Force-all-low low drives all outputs low, stages untouched
// - Force-all-low high and gate low: each output follows its stage
package electrode_pkg;
  localparam int          STAGES      = 32;
  localparam int          FIFO_DEPTH  = 8;
  localparam int          FIFO_WIDTH  = 1;
  localparam logic [31:0] STAGE_RST   = 32'h0000_0000;
  localparam logic [31:0] DRIVE_RST   = 32'hFFFF_FFFF;
  localparam logic [31:0] DRIVE_ALL_H = 32'hFFFF_FFFF;
  localparam logic [31:0] DRIVE_ALL_L = 32'h0000_0000;
  localparam logic        LEVEL_RST   = 1'h0;
endpackage

// ---- src/plasma_electrode_shift_driver.sv ----
// 32-stage serial-in parallel-out electrode driver with gating controls
`timescale 1ns/10ps
module plasma_electrode_shift_driver #(
  parameter int STAGES = electrode_pkg::STAGES,
  parameter int DEPTH  = electrode_pkg::FIFO_DEPTH
) (
  input  wire logic              sys_clk_i,
  input  wire logic              srst_i,
  input  wire logic              shift_clk_i,
  input  wire logic              serial_data_i,
  input  wire logic              out_gate_n_i,
  input  wire logic              force_low_n_i,
  input  wire logic              shift_hold_i,
  output logic                   fifo_ready_o,
  output logic                   cascade_o,
  output logic      [STAGES-1:0] drive_o
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic              shclk_ff;
  logic              nxt_shclk;
  logic              rise;
  logic              f_ready;
  logic              f_valid;
  logic              f_data;
  logic              pop;
  logic [STAGES-1:0] stage_ff;
  logic [STAGES-1:0] nxt_stage;
  logic [STAGES-1:0] drive_ff;
  logic [STAGES-1:0] nxt_drive;
  logic              cascade_ff;
  logic              nxt_cascade;
  logic              ready_ff;
  logic              nxt_ready;

  ////////////////////////////////////////////////////////////////////////
  // Shift clock edge detect; pin is already synchronous to sys_clk_i
  assign nxt_shclk = shift_clk_i;
  assign rise      = shift_clk_i && !shclk_ff;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      shclk_ff <= electrode_pkg::LEVEL_RST;
    end else begin
      shclk_ff <= nxt_shclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Each captured bit waits here while shift_hold_i freezes the stages.
  // A rise seen while the FIFO is full is dropped; fifo_ready_o warns.
  bit_fifo #(
    .WIDTH (1),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (rise),
    .in_ready_o  (f_ready),
    .in_data_i   (serial_data_i),
    .out_valid_o (f_valid),
    .out_ready_i (!shift_hold_i),
    .out_data_o  (f_data)
  );

  assign pop = f_valid && !shift_hold_i;

  ////////////////////////////////////////////////////////////////////////
  // Shift path: one stage step per captured rising edge
  always_comb begin
    nxt_stage = stage_ff;
    if (pop) begin
      nxt_stage = {stage_ff[STAGES-2:0], f_data};
    end
    nxt_cascade = nxt_stage[STAGES-1];
    nxt_ready   = f_ready;
  end

  // Stage contents are undefined to the user until a full load
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      stage_ff   <= electrode_pkg::STAGE_RST;
      cascade_ff <= electrode_pkg::LEVEL_RST;
      ready_ff   <= electrode_pkg::LEVEL_RST;
    end else begin
      stage_ff   <= nxt_stage;
      cascade_ff <= nxt_cascade;
      ready_ff   <= nxt_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output gating; registered for clean outputs, costing one cycle
  always_comb begin
    if (!force_low_n_i) begin
      nxt_drive = electrode_pkg::DRIVE_ALL_L;
    end else if (out_gate_n_i) begin
      nxt_drive = electrode_pkg::DRIVE_ALL_H;
    end else begin
      nxt_drive = stage_ff;
    end
  end

  // Gating does not wait for the shift clock
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      drive_ff <= electrode_pkg::DRIVE_RST;
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  assign drive_o      = drive_ff;
  assign cascade_o    = cascade_ff;
  assign fifo_ready_o = ready_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_rise_idle;
    rise && !f_valid && !shift_hold_i;
  endsequence

  sequence s_drain;
    !shift_hold_i;
  endsequence

  a_edge_to_stage: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    s_rise_idle ##1 s_drain |=> stage_ff[0] == $past(serial_data_i, 2))
    else $error("captured bit did not reach the first stage");

  a_shift_move: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    pop |=> stage_ff[STAGES-1:1] == $past(stage_ff[STAGES-2:0]))
    else $error("stages did not move one place");

  a_hold_stages: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    !f_valid |=> $stable(stage_ff))
    else $error("stages changed without a shift");

  a_cascade_last: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    $changed(cascade_o) |-> $past(pop) && cascade_o == stage_ff[STAGES-1])
    else $error("cascade output not tied to last stage shift");

  a_force_low: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    !force_low_n_i |=> drive_o == '0)
    else $error("outputs not forced low");

  a_force_keeps: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    !force_low_n_i && !pop |=> $stable(stage_ff))
    else $error("force low disturbed the stages");

  a_gate_high: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    force_low_n_i && out_gate_n_i |=> &drive_o)
    else $error("gated outputs not all high");

  a_follow_stage: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    force_low_n_i && !out_gate_n_i |=> drive_o == $past(stage_ff))
    else $error("outputs do not follow stages");

  a_ctrl_no_clock: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    !shift_clk_i [*2] ##0 !force_low_n_i |=> drive_o == '0)
    else $error("control needed the shift clock");

  ////////////////////////////////////////////////////////////////////////
  // Further checks across the queue, the cascade and the gating
  sequence s_pop;
    pop;
  endsequence

  sequence s_open;
    force_low_n_i && !out_gate_n_i;
  endsequence

  sequence s_shut;
    force_low_n_i && out_gate_n_i;
  endsequence

  a_push_queue: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    rise && f_ready |=> f_valid)
    else $error("accepted bit was not queued");

  a_hold_freeze: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    shift_hold_i |=> $stable(stage_ff))
    else $error("stages moved while held");

  a_idle_cascade: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    !f_valid |=> $stable(cascade_o))
    else $error("cascade moved with nothing queued");

  // Cascade is a registered copy, so it must never drift from the stage
  a_cascade_mirror: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    cascade_o == stage_ff[STAGES-1])
    else $error("cascade differs from last stage");

  a_cascade_step: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    s_pop |=> cascade_o == $past(stage_ff[STAGES-2]))
    else $error("cascade did not take the next stage");

  a_force_priority: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    !force_low_n_i && out_gate_n_i |=> drive_o == '0)
    else $error("gate high overrode force low");

  a_gate_shifting: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    s_pop ##0 s_shut |=> &drive_o)
    else $error("outputs dropped while shifting");

  a_follow_shift: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    s_pop ##1 s_open |=> drive_o[0] == $past(f_data, 2))
    else $error("shifted bit not shown on first output");

  // Gate acts on the next system edge, with no shift clock needed
  a_gate_fall: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    $fell(out_gate_n_i) && force_low_n_i |=> drive_o == $past(stage_ff))
    else $error("gate release did not show the stages");
endmodule

// ---- testbench/shift_controller.sv ----
// Display controller model that clocks 32-bit words into the driver
`timescale 1ns/10ps
module shift_controller (
  input  wire logic        sys_clk_i,
  input  wire logic        go_i,
  input  wire logic        slow_i,
  input  wire logic [31:0] word_i,
  output logic             shift_clk_o,
  output logic             data_o,
  output logic             busy_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle levels at time zero
  initial begin
    shift_clk_o = 1'h0;
    data_o      = 1'h0;
    busy_o      = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Msb first, so the first bit sent ends up in the last stage
  always @(posedge sys_clk_i) begin
    if (go_i && !busy_o) begin
      busy_o <= 1'h1;
      for (int i = 31; i >= 0; i--) begin
        shift_clk_o <= 1'h1;
        data_o      <= word_i[i];
        @(posedge sys_clk_i);
        // Data no longer held once the clock falls: show the inverse
        shift_clk_o <= 1'h0;
        data_o      <= ~word_i[i];
        repeat (slow_i ? 3 : 0) @(posedge sys_clk_i);
        @(posedge sys_clk_i);
      end
      busy_o <= 1'h0;
    end
  end
endmodule

// ---- testbench/test_plasma_electrode_shift_driver.sv ----
// Self-checking bench for the plasma electrode shift driver
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  err_total++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_plasma_electrode_shift_driver;
  logic        sys_clk_i     = 1'h0;
  logic        srst_i        = 1'h1;
  logic        out_gate_n_i  = 1'h1;
  logic        force_low_n_i = 1'h1;
  logic        shift_hold_i  = 1'h0;
  logic        go            = 1'h0;
  logic        slow          = 1'h0;
  logic [31:0] word          = 32'h0000_0000;
  logic        shift_clk;
  logic        sdata;
  logic        busy;
  logic        fifo_ready;
  logic        cascade;
  logic [31:0] drive;
  int          err_total     = 0;
  int          num_checks    = 0;
  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz system clock
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  plasma_electrode_shift_driver dut_u (
    .sys_clk_i     (sys_clk_i),
    .srst_i        (srst_i),
    .shift_clk_i   (shift_clk),
    .serial_data_i (sdata),
    .out_gate_n_i  (out_gate_n_i),
    .force_low_n_i (force_low_n_i),
    .shift_hold_i  (shift_hold_i),
    .fifo_ready_o  (fifo_ready),
    .cascade_o     (cascade),
    .drive_o       (drive)
  );
  shift_controller ctl_u (
    .sys_clk_i   (sys_clk_i),
    .go_i        (go),
    .slow_i      (slow),
    .word_i      (word),
    .shift_clk_o (shift_clk),
    .data_o      (sdata),
    .busy_o      (busy)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // Start a frame and wait, bounded, until the controller is idle
  task automatic send(input logic [31:0] w, input logic s);
    word <= w;
    slow <= s;
    go   <= 1'h1;
    step(1);
    go <= 1'h0;
    for (int i = 0; i < 800; i++) begin
      step(1);
      #1;
      if (busy !== 1'h1) return;
    end
    err_total++;
    final_report();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Gate high hides the data, gate low shows every stage
  task automatic t_gate();
    step(1);
    send(32'hA5C3_0F96, 1'h0);
    `CHK("drive_all_high", electrode_pkg::DRIVE_ALL_H, drive)
    step(1);
    out_gate_n_i <= 1'h0;
    step(4);
    #1;
    `CHK("drive_follow", 32'hA5C3_0F96, drive)
    `CHK("cascade", 1'h1, cascade)
  endtask
  // Force low while a slow frame shifts, then stages show again
  task automatic t_force();
    step(1);
    force_low_n_i <= 1'h0;
    send(32'h3C5A_F00F, 1'h1);
    `CHK("drive_forced", electrode_pkg::DRIVE_ALL_L, drive)
    step(1);
    out_gate_n_i <= 1'h1;
    step(3);
    #1;
    `CHK("drive_forced_gate", electrode_pkg::DRIVE_ALL_L, drive)
    step(1);
    out_gate_n_i  <= 1'h0;
    force_low_n_i <= 1'h1;
    step(3);
    #1;
    `CHK("drive_after_force", 32'h3C5A_F00F, drive)
    `CHK("cascade_kept", 1'h0, cascade)
  endtask
  // Hold fills the queue, later rises are lost, then 8 bits drain
  task automatic t_hold();
    step(1);
    shift_hold_i <= 1'h1;
    send(32'hF0E1_D2C3, 1'h0);
    step(2);
    #1;
    `CHK("fifo_full", 1'h0, fifo_ready)
    `CHK("drive_frozen", 32'h3C5A_F00F, drive)
    step(1);
    shift_hold_i <= 1'h0;
    step(20);
    #1;
    `CHK("drive_drained", 32'h5AF0_0FF0, drive)
    `CHK("cascade_drained", 1'h0, cascade)
    `CHK("fifo_empty", 1'h1, fifo_ready)
  endtask
  // Outputs just after reset: gate high shows all high, cascade low
  task automatic t_reset();
    step(2);
    #1;
    `CHK("drive_reset", electrode_pkg::DRIVE_RST, drive)
    `CHK("cascade_reset", electrode_pkg::LEVEL_RST, cascade)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset for 6 cycles, then each scenario in turn
  initial begin
    repeat (6) @(posedge sys_clk_i);
    srst_i <= 1'h0;
    t_reset();
    t_gate();
    t_force();
    t_hold();
    final_report();
  end
endmodule
